// ---- design/mmc_core.sv ----
// Command and status logic of a pulse-train motion module.
// Assumes one clock, a host presenting one-cycle command strobes, and
// a software-filled table memory reached over a plain register port.
//
// Added by the designer: the strobed register port and the address map.
module mmc_core
(
  // Clock, enable and reset
  input wire logic clk_sys_in,
  input wire logic clk_en_in,
  input wire logic rst_n_in,
  // Table register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Host command port
  input wire logic module_enable_in,
  input wire logic run_mode_entry_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  // Manual mode inputs
  input wire logic man_run_in,
  input wire logic man_jog_pos_in,
  input wire logic man_jog_neg_in,
  input wire logic man_dir_in,
  input wire logic [31:0] man_speed_in,
  // Status
  output logic done_out,
  output logic busy_out,
  output logic manual_active_out,
  output logic [7:0] error_out,
  output logic [31:0] cur_pos_out,
  output logic [31:0] cur_speed_out,
  output logic cur_dir_out,
  output logic units_eng_out,
  // Motor pins
  output logic pulse_out,
  output logic dir_pin_out
);

  mmc_pkg::mmc_state_type state;
  logic [31:0] jog_step;
  logic [31:0] jog_speed;
  logic [31:0] accel;
  logic [31:0] start_speed;
  logic units_eng;
  logic [mmc_pkg::CFG_AW:0] load_idx;
  logic [mmc_pkg::CFG_AW-1:0] load_addr_q;
  logic load_rd_valid;
  logic [31:0] mem_rdata;
  logic [31:0] target_speed;
  logic [31:0] phase;
  logic [32:0] next_phase;
  logic pulse_due;
  logic [31:0] pulses_left;
  logic [31:0] jog_timer;
  logic jog_dir;
  logic move_dir;
  logic enable_q;
  logic cmd_accept;
  logic cmd_refuse;
  logic [7:0] refuse_code;
  logic jog_any;
  logic pending_load;

  function automatic logic is_table_addr(input logic [7:0] addr);
    return addr < 8'(mmc_pkg::CFG_WORDS);
  endfunction

  mmc_table_mem u_mem
  (
    .clk_sys_in(clk_sys_in),
    .clk_en_in(clk_en_in),
    .wr_en_in(reg_wr_in && is_table_addr(reg_addr_in)),
    .wr_addr_in(reg_addr_in[mmc_pkg::CFG_AW-1:0]),
    .wr_data_in(reg_wdata_in),
    .rd_addr_in(state == mmc_pkg::ST_LOAD ? load_idx[mmc_pkg::CFG_AW-1:0] : reg_addr_in[mmc_pkg::CFG_AW-1:0]),
    .rd_data_out(mem_rdata)
  );

  // Read data for software: table words outside a load, zero elsewhere, one cycle later.
  logic rd_hit;
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_hit <= 1'b0;
    end
    else if (clk_en_in)
    begin
      rd_hit <= reg_rd_in && is_table_addr(reg_addr_in) && state != mmc_pkg::ST_LOAD;
    end
  end
  assign reg_rdata_out = rd_hit ? mem_rdata : 32'h0000_0000;

  assign jog_any = man_jog_pos_in || man_jog_neg_in;
  assign busy_out = state != mmc_pkg::ST_IDLE;
  assign manual_active_out = state == mmc_pkg::ST_MANUAL || state == mmc_pkg::ST_JOG_STEP;
  assign units_eng_out = units_eng;

  // Command admission.
  always_comb
  begin
    cmd_accept = 1'b0;
    cmd_refuse = 1'b0;
    refuse_code = mmc_pkg::ERR_NONE;
    if (cmd_valid_in && cmd_code_in != mmc_pkg::CMD_CONTROL && cmd_code_in != mmc_pkg::CMD_NONE)
    begin
      if (!module_enable_in)
      begin
        cmd_refuse = 1'b1;
        refuse_code = mmc_pkg::ERR_DISABLED;
      end
      else if (manual_active_out && cmd_code_in != mmc_pkg::CMD_DISABLE)
      begin
        cmd_refuse = 1'b1;
        refuse_code = mmc_pkg::ERR_MANUAL;
      end
      else if (busy_out && !manual_active_out)
      begin
        cmd_refuse = 1'b1;
        refuse_code = mmc_pkg::ERR_BUSY;
      end
      else
      begin
        cmd_accept = 1'b1;
      end
    end
  end

  // Pulse generator: phase accumulator driven by the current speed.
  assign next_phase = {1'b0, phase} + {1'b0, cur_speed_out};
  assign pulse_due = next_phase[32] && cur_speed_out != 32'h0000_0000;

  // Main sequencer.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= mmc_pkg::ST_LOAD;
      load_idx <= '0;
      load_rd_valid <= 1'b0;
      load_addr_q <= '0;
      done_out <= 1'b0;
      error_out <= mmc_pkg::ERR_NONE;
      enable_q <= 1'b0;
      pending_load <= 1'b0;
      jog_timer <= 32'h0000_0000;
      pulses_left <= 32'h0000_0000;
      jog_dir <= 1'b1;
      target_speed <= 32'h0000_0000;
    end
    else if (clk_en_in)
    begin
      done_out <= 1'b0;
      enable_q <= module_enable_in;
      if (run_mode_entry_in)
      begin
        pending_load <= 1'b1;
      end
      if (enable_q && !module_enable_in && state != mmc_pkg::ST_IDLE && state != mmc_pkg::ST_LOAD)
      begin
        target_speed <= 32'h0000_0000;
        state <= mmc_pkg::ST_RAMP_DOWN;
        error_out <= mmc_pkg::ERR_ABORTED;
      end
      else
      begin
        unique case (state)
          mmc_pkg::ST_IDLE:
          begin
            if (pending_load || (cmd_accept && cmd_code_in == mmc_pkg::CMD_RELOAD))
            begin
              pending_load <= 1'b0;
              load_idx <= '0;
              load_rd_valid <= 1'b0;
              state <= mmc_pkg::ST_LOAD;
            end
            else if (cmd_accept && cmd_code_in == mmc_pkg::CMD_MANUAL)
            begin
              error_out <= mmc_pkg::ERR_NONE;
              jog_timer <= 32'h0000_0000;
              state <= mmc_pkg::ST_MANUAL;
            end
            else if (cmd_accept && cmd_code_in == mmc_pkg::CMD_DISABLE)
            begin
              error_out <= mmc_pkg::ERR_NONE;
              done_out <= 1'b1;
            end
            else if (cmd_accept)
            begin
              // Seek, goto, profile and offset loads live in another block.
              error_out <= mmc_pkg::ERR_UNSUPPORTED;
              done_out <= 1'b1;
            end
          end
          mmc_pkg::ST_LOAD:
          begin
            load_rd_valid <= load_idx < (mmc_pkg::CFG_AW+1)'(mmc_pkg::CFG_WORDS);
            load_addr_q <= load_idx[mmc_pkg::CFG_AW-1:0];
            if (load_idx < (mmc_pkg::CFG_AW+1)'(mmc_pkg::CFG_WORDS))
            begin
              load_idx <= load_idx + 1'b1;
            end
            else if (!load_rd_valid)
            begin
              done_out <= 1'b1;
              error_out <= mmc_pkg::ERR_NONE;
              state <= mmc_pkg::ST_IDLE;
            end
          end
          mmc_pkg::ST_MANUAL:
          begin
            if (cmd_accept && cmd_code_in == mmc_pkg::CMD_DISABLE)
            begin
              target_speed <= 32'h0000_0000;
              state <= mmc_pkg::ST_RAMP_DOWN;
            end
            else if (man_run_in)
            begin
              target_speed <= man_speed_in;
              jog_dir <= man_dir_in;
            end
            else if (jog_any)
            begin
              jog_dir <= man_jog_pos_in;
              if (jog_timer < mmc_pkg::JOG_LONG_CYC)
              begin
                jog_timer <= jog_timer + 32'h0000_0001;
                target_speed <= 32'h0000_0000;
              end
              else
              begin
                target_speed <= jog_speed;
              end
            end
            else
            begin
              target_speed <= 32'h0000_0000;
              if (jog_timer != 32'h0000_0000 && jog_timer < mmc_pkg::JOG_LONG_CYC)
              begin
                pulses_left <= jog_step;
                target_speed <= jog_speed;
                state <= mmc_pkg::ST_JOG_STEP;
              end
              jog_timer <= 32'h0000_0000;
            end
          end
          mmc_pkg::ST_JOG_STEP:
          begin
            if (cmd_accept && cmd_code_in == mmc_pkg::CMD_DISABLE)
            begin
              target_speed <= 32'h0000_0000;
              pulses_left <= 32'h0000_0000;
              state <= mmc_pkg::ST_RAMP_DOWN;
            end
            else if (pulses_left == 32'h0000_0000)
            begin
              target_speed <= 32'h0000_0000;
              done_out <= 1'b1;
              error_out <= mmc_pkg::ERR_NONE;
              state <= mmc_pkg::ST_MANUAL;
            end
            else if (pulse_due)
            begin
              pulses_left <= pulses_left - 32'h0000_0001;
            end
          end
          mmc_pkg::ST_RAMP_DOWN:
          begin
            if (cur_speed_out == 32'h0000_0000)
            begin
              done_out <= 1'b1;
              state <= mmc_pkg::ST_IDLE;
            end
          end
          default:
          begin
            state <= mmc_pkg::ST_IDLE;
          end
        endcase
      end
      // refusal code wins
      // Placed last so that a finish in the same cycle cannot hide the refusal code.
      if (cmd_refuse)
      begin
        error_out <= refuse_code;
        done_out <= 1'b1;
      end
    end
  end

  // Working configuration, captured from the table during a load.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      jog_step <= mmc_pkg::JOG_STEP_RST;
      jog_speed <= mmc_pkg::JOG_SPEED_RST;
      accel <= mmc_pkg::ACCEL_RST;
      start_speed <= mmc_pkg::START_SPEED_RST;
      units_eng <= 1'b0;
    end
    else if (clk_en_in && load_rd_valid)
    begin
      unique case (load_addr_q)
        mmc_pkg::CFG_JOG_STEP: jog_step <= mem_rdata;
        mmc_pkg::CFG_JOG_SPEED: jog_speed <= mem_rdata;
        mmc_pkg::CFG_ACCEL: accel <= mem_rdata;
        mmc_pkg::CFG_START_SPEED: start_speed <= mem_rdata;
        mmc_pkg::CFG_UNITS: units_eng <= mem_rdata[0];
        default: ;
      endcase
    end
  end

  // Speed ramp; the step-down in the jog finish never reverses the motor.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cur_speed_out <= 32'h0000_0000;
    end
    else if (clk_en_in)
    begin
      // stop after last pulse
      // Ramping down here would emit pulses beyond the jog step.
      if (state == mmc_pkg::ST_JOG_STEP && pulses_left == 32'h0000_0000)
      begin
        cur_speed_out <= 32'h0000_0000;
      end
      else if (cur_speed_out < target_speed)
      begin
        if (cur_speed_out < start_speed && start_speed <= target_speed)
        begin
          cur_speed_out <= start_speed;
        end
        else if (target_speed - cur_speed_out > accel)
        begin
          cur_speed_out <= cur_speed_out + accel;
        end
        else
        begin
          cur_speed_out <= target_speed;
        end
      end
      else if (cur_speed_out > target_speed)
      begin
        if (cur_speed_out - target_speed > accel && cur_speed_out > start_speed)
        begin
          cur_speed_out <= cur_speed_out - accel;
        end
        else
        begin
          cur_speed_out <= target_speed;
        end
      end
    end
  end

  // Pulse output, position count and direction.
  assign move_dir = jog_dir;
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase <= 32'h0000_0000;
      pulse_out <= 1'b0;
      cur_pos_out <= 32'h0000_0000;
      cur_dir_out <= 1'b1;
      dir_pin_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      phase <= next_phase[31:0];
      pulse_out <= pulse_due && (state != mmc_pkg::ST_JOG_STEP || pulses_left != 32'h0000_0000);
      if (cur_speed_out == 32'h0000_0000)
      begin
        dir_pin_out <= move_dir;
        cur_dir_out <= move_dir;
      end
      if (pulse_due && (state != mmc_pkg::ST_JOG_STEP || pulses_left != 32'h0000_0000))
      begin
        cur_pos_out <= dir_pin_out ? cur_pos_out + 32'h0000_0001 : cur_pos_out - 32'h0000_0001;
      end
    end
  end

endmodule

// ---- design/mmc_pkg.sv ----
// Constants and types shared by the motion command block and its table memory.
// Assumes one 250 MHz clock; the jog threshold in cycles is derived from that rate.
package mmc_pkg;

  localparam int unsigned CLK_HZ = 250000000;
  // Jog press threshold in milliseconds, as a time.
  localparam int unsigned JOG_LONG_MS = 500;
  localparam longint unsigned JOG_LONG_CYC_L = (longint'(CLK_HZ) * JOG_LONG_MS + 999) / 1000;
  localparam int unsigned JOG_LONG_CYC = int'(JOG_LONG_CYC_L);

  localparam int unsigned CFG_WORDS = 8;
  localparam int unsigned CFG_AW = 3;

  // Configuration table word indices.
  localparam logic [2:0] CFG_JOG_STEP = 3'h0;
  localparam logic [2:0] CFG_JOG_SPEED = 3'h1;
  localparam logic [2:0] CFG_ACCEL = 3'h2;
  localparam logic [2:0] CFG_START_SPEED = 3'h3;
  localparam logic [2:0] CFG_UNITS = 3'h4;

  // Reset contents of the working configuration.
  localparam logic [31:0] JOG_STEP_RST = 32'h0000_0064;
  localparam logic [31:0] JOG_SPEED_RST = 32'h0000_1000;
  localparam logic [31:0] ACCEL_RST = 32'h0000_0010;
  localparam logic [31:0] START_SPEED_RST = 32'h0000_0100;

  // Pulse rate accumulator: a pulse is due each time the phase wraps.
  localparam logic [31:0] PHASE_STEP_DIV = 32'h0000_0001;

  // Command codes on the command port.
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_CONTROL = 4'h1;
  localparam logic [3:0] CMD_MANUAL = 4'h2;
  localparam logic [3:0] CMD_DISABLE = 4'h3;
  localparam logic [3:0] CMD_RSEEK = 4'h4;
  localparam logic [3:0] CMD_LOADPOS = 4'h5;
  localparam logic [3:0] CMD_GOTO = 4'h6;
  localparam logic [3:0] CMD_PROFILE = 4'h7;
  localparam logic [3:0] CMD_RELOAD = 4'h8;

  // Error codes.
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_DISABLED = 8'h01;
  localparam logic [7:0] ERR_BUSY = 8'h02;
  localparam logic [7:0] ERR_MANUAL = 8'h03;
  localparam logic [7:0] ERR_ABORTED = 8'h04;
  localparam logic [7:0] ERR_UNSUPPORTED = 8'h05;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_MANUAL,
    ST_JOG_STEP,
    ST_RAMP_DOWN
  } mmc_state_type;

endpackage

// ---- design/mmc_table_mem.sv ----
// Small configuration table memory: one write port, registered read data.
// Assumes the writer and reader share clk_sys_in.
module mmc_table_mem
(
  // Clock and enable
  input wire logic clk_sys_in,
  input wire logic clk_en_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [mmc_pkg::CFG_AW-1:0] wr_addr_in,
  input wire logic [31:0] wr_data_in,
  // Read port
  input wire logic [mmc_pkg::CFG_AW-1:0] rd_addr_in,
  output logic [31:0] rd_data_out
);

  logic [31:0] mem [mmc_pkg::CFG_WORDS];

  always_ff @(posedge clk_sys_in)
  begin
    if (clk_en_in && wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (clk_en_in)
    begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule

// ---- tb/mmc_core_props.sv ----
// Checker for the motion command block: refusals, completion, stillness and direction at its ports.
// Assumes one clock domain and clk_en_in held high by the user of the block.
module mmc_core_props
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Host side
  input wire logic module_enable_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic man_run_in,
  // Status and motor side
  input wire logic done_out,
  input wire logic busy_out,
  input wire logic manual_active_out,
  input wire logic [7:0] error_out,
  input wire logic [31:0] cur_pos_out,
  input wire logic [31:0] cur_speed_out,
  input wire logic cur_dir_out,
  input wire logic pulse_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  logic real_cmd;
  assign real_cmd = cmd_valid_in && cmd_code_in != mmc_pkg::CMD_NONE && cmd_code_in != mmc_pkg::CMD_CONTROL;

  disabled_refuse_a: assert property (
    real_cmd && !module_enable_in |=> done_out && error_out == mmc_pkg::ERR_DISABLED)
    else $error("command taken while disabled");
  manual_refuse_a: assert property (
    real_cmd && module_enable_in && manual_active_out && cmd_code_in != mmc_pkg::CMD_DISABLE
    |=> done_out && error_out == mmc_pkg::ERR_MANUAL)
    else $error("command taken in manual mode");
  busy_refuse_a: assert property (
    real_cmd && module_enable_in && busy_out && !manual_active_out |=> done_out && error_out == mmc_pkg::ERR_BUSY)
    else $error("command taken while busy");
  abort_done_a: assert property (
    $fell(module_enable_in) && busy_out |-> ##[1:1000] (done_out && error_out == mmc_pkg::ERR_ABORTED))
    else $error("no abort after enable dropped");
  finish_done_a: assert property (
    $fell(busy_out) |-> ##[0:1] done_out)
    else $error("command ended without done");
  idle_still_a: assert property (
    !busy_out |-> cur_speed_out == 32'h0)
    else $error("motor moving while idle");
  release_slow_a: assert property (
    $fell(man_run_in) && manual_active_out |=> (cur_speed_out <= $past(cur_speed_out))[*8])
    else $error("speed rose after run released");
  dir_hold_a: assert property (
    $changed(cur_dir_out) |-> $past(cur_speed_out) == 32'h0)
    else $error("direction changed while moving");
  pos_pulse_a: assert property (
    $changed(cur_pos_out) |-> pulse_out || $past(pulse_out))
    else $error("position moved without a pulse");
endmodule

bind mmc_core mmc_core_props i_mmc_core_props
(
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .module_enable_in(module_enable_in),
  .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in), .man_run_in(man_run_in), .done_out(done_out),
  .busy_out(busy_out), .manual_active_out(manual_active_out), .error_out(error_out),
  .cur_pos_out(cur_pos_out), .cur_speed_out(cur_speed_out), .cur_dir_out(cur_dir_out), .pulse_out(pulse_out)
);

// ---- tb/mmc_host_model.sv ----
// Host controller model: a control call every scan and one motion command at a time.
// Assumes issue is called at a rising edge and busy_in is the block's busy flag.
module mmc_host_model
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Block status
  input wire logic busy_in,
  // Command strobe
  output logic cmd_valid_out,
  output logic [3:0] cmd_code_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] scan_cnt;
  logic scan_valid;
  logic user_valid = 1'b0;
  logic [3:0] user_code = 4'h0;
  always @(posedge clk_sys_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      scan_cnt <= 4'h0;
      scan_valid <= 1'b0;
    end
    else
    begin
      scan_cnt <= scan_cnt + 4'h1;
      scan_valid <= (scan_cnt == 4'hf);
    end
  assign cmd_valid_out = scan_valid | user_valid;
  assign cmd_code_out = user_valid ? user_code : mmc_pkg::CMD_CONTROL;
  task issue(input logic [3:0] code, input bit wait_idle);
    int n;
    n = 0;
    while (((wait_idle && busy_in) || scan_cnt == 4'hf) && n < 4000)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    user_code <= code;
    user_valid <= 1'b1;
    @(posedge clk_sys_in);
    user_valid <= 1'b0;
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the motion command block: table, refusals, jogs, run and abort.
// Assumes the host model owns the command strobe; the bench drives every other input.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1, module_enable_in = 1'b1, run_mode_entry_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, man_run_in = 1'b0, man_jog_pos_in = 1'b0, man_jog_neg_in = 1'b0;
  logic man_dir_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, man_speed_in = 32'h0;
  logic cmd_valid_in, done_out, busy_out, manual_active_out, cur_dir_out, units_eng_out, pulse_out, dir_pin_out;
  logic [3:0] cmd_code_in;
  logic [7:0] error_out;
  logic [31:0] reg_rdata_out, cur_pos_out, cur_speed_out;
  logic [31:0] tbl [5] = '{32'h5, 32'h4000_0000, 32'h1000_0000, 32'h1000_0000, 32'h1};
  int n_fail = 0, tests_run = 0, n_pulse = 0, p0;

  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (pulse_out) n_pulse <= n_pulse + 1;

  mmc_core i_mmc_core
  (
    .clk_sys_in(clk_sys_in), .clk_en_in(clk_en_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .module_enable_in(module_enable_in), .run_mode_entry_in(run_mode_entry_in), .cmd_valid_in(cmd_valid_in),
    .cmd_code_in(cmd_code_in), .man_run_in(man_run_in), .man_jog_pos_in(man_jog_pos_in),
    .man_jog_neg_in(man_jog_neg_in), .man_dir_in(man_dir_in), .man_speed_in(man_speed_in), .done_out(done_out),
    .busy_out(busy_out), .manual_active_out(manual_active_out), .error_out(error_out), .cur_pos_out(cur_pos_out),
    .cur_speed_out(cur_speed_out), .cur_dir_out(cur_dir_out), .units_eng_out(units_eng_out),
    .pulse_out(pulse_out), .dir_pin_out(dir_pin_out)
  );
  mmc_host_model i_mmc_host_model
  (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .busy_in(busy_out), .cmd_valid_out(cmd_valid_in),
    .cmd_code_out(cmd_code_in)
  );

  task check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
  endtask
  task reg_rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 check(reg_rdata_out, exp);
    @(posedge clk_sys_in);
  endtask
  task wait_done(input int lim);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    while (done_out !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    #1 check(n < lim, 1'b1);
    @(posedge clk_sys_in);
  endtask
  task cmd(input logic [3:0] c, input bit idle, input logic [7:0] err);
    i_mmc_host_model.issue(c, idle);
    #1 check({done_out, error_out}, {1'b1, err});
    @(posedge clk_sys_in);
  endtask
  task tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    // The table is filled across the reset release, each of the five words written before the power-up load reads it.
    fork
      begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
      end
      begin
        @(posedge clk_sys_in);
        foreach (tbl[i]) reg_wr(8'(i), (i == 4) ? 32'h0 : tbl[i]);
      end
    join
    reg_wr_in <= 1'b0;
    check({cur_dir_out, busy_out, cur_pos_out}, {1'b1, 1'b1, 32'h0});
    cmd(mmc_pkg::CMD_GOTO, 1'b0, mmc_pkg::ERR_BUSY);
    wait_done(200);
    // A fast, steep table so that jogs and ramps finish in a few dozen cycles.
    foreach (tbl[i]) reg_wr(8'(i), tbl[i]);
    reg_wr_in <= 1'b0;
    foreach (tbl[i]) reg_rd(8'(i), tbl[i]);
    reg_rd(8'h20, 32'h0);
    check(units_eng_out, 1'b0);
    i_mmc_host_model.issue(mmc_pkg::CMD_RELOAD, 1'b1);
    wait_done(200);
    check({units_eng_out, error_out}, {1'b1, mmc_pkg::ERR_NONE});
    reg_wr(8'h04, 32'h0);
    reg_wr_in <= 1'b0;
    run_mode_entry_in <= 1'b1;
    @(posedge clk_sys_in);
    run_mode_entry_in <= 1'b0;
    wait_done(200);
    check(units_eng_out, 1'b0);
    @(posedge clk_sys_in);
    for (logic [3:0] c = mmc_pkg::CMD_RSEEK; c <= mmc_pkg::CMD_PROFILE; c++)
      cmd(c, 1'b1, mmc_pkg::ERR_UNSUPPORTED);
    module_enable_in <= 1'b0;
    cmd(mmc_pkg::CMD_MANUAL, 1'b1, mmc_pkg::ERR_DISABLED);
    module_enable_in <= 1'b1;
    i_mmc_host_model.issue(mmc_pkg::CMD_MANUAL, 1'b1);
    #1 check(manual_active_out, 1'b1);
    @(posedge clk_sys_in);
    cmd(mmc_pkg::CMD_GOTO, 1'b0, mmc_pkg::ERR_MANUAL);
    for (int d = 1; d >= 0; d--)
    begin
      p0 = n_pulse;
      man_jog_pos_in <= (d == 1);
      man_jog_neg_in <= (d == 0);
      repeat (3) @(posedge clk_sys_in);
      man_jog_pos_in <= 1'b0;
      man_jog_neg_in <= 1'b0;
      wait_done(2000);
      check(40'(n_pulse - p0), 40'h5);
      check({cur_dir_out, dir_pin_out, cur_pos_out}, {d[0], d[0], (d == 1) ? 32'h5 : 32'h0});
      @(posedge clk_sys_in);
    end
    man_speed_in <= 32'h2000_0000;
    man_run_in <= 1'b1;
    repeat (40) @(posedge clk_sys_in);
    check(cur_speed_out, 32'h2000_0000);
    man_speed_in <= 32'h3000_0000;
    repeat (40) @(posedge clk_sys_in);
    check(cur_speed_out, 32'h3000_0000);
    // A low clock enable must freeze speed and position.
    clk_en_in <= 1'b0;
    @(posedge clk_sys_in);
    p0 = cur_pos_out;
    repeat (10) @(posedge clk_sys_in);
    check(cur_speed_out, 32'h3000_0000);
    check(cur_pos_out, 32'(p0));
    clk_en_in <= 1'b1;
    man_run_in <= 1'b0;
    repeat (40) @(posedge clk_sys_in);
    check({manual_active_out, cur_speed_out}, {1'b1, 32'h0});
    man_run_in <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    module_enable_in <= 1'b0;
    wait_done(500);
    check({manual_active_out, error_out}, {1'b0, mmc_pkg::ERR_ABORTED});
    @(posedge clk_sys_in);
    man_run_in <= 1'b0;
    module_enable_in <= 1'b1;
    @(posedge clk_sys_in);
    i_mmc_host_model.issue(mmc_pkg::CMD_MANUAL, 1'b1);
    @(posedge clk_sys_in);
    i_mmc_host_model.issue(mmc_pkg::CMD_DISABLE, 1'b0);
    wait_done(200);
    check({manual_active_out, error_out}, {1'b0, mmc_pkg::ERR_NONE});
    tally_and_finish();
  end
endmodule
